// File: rtl/swsc_pkg.sv
// ----------------------------------------------------------------------
// Shared constants for the standby wake source configuration block
// ----------------------------------------------------------------------
package swsc_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses on the local register port)
  // ----------------------------------------------------------------------
  localparam logic [7:0]  CFG_OFFSET    = 8'h14;
  localparam logic [7:0]  STATUS_OFFSET = 8'h40;

  // ----------------------------------------------------------------------
  // Field layout of the configuration word, one byte lane per input
  // ----------------------------------------------------------------------
  localparam int          NUM_LANES     = 4;
  localparam int          LANE_W        = 8;
  localparam int          EN_POS        = 0;
  localparam int          COND_POS      = 4;
  localparam int          COND_W        = 2;

  // Writable bits: enable and condition field of each lane
  localparam logic [31:0] CFG_WMASK     = 32'h31313131;
  // Bits 7:6 and 3:1 of each lane always read back as zero
  localparam logic [31:0] CFG_RESV_MASK = 32'hcececece;
  // Falling edge selected and wake disabled in every lane
  localparam logic [31:0] CFG_RESET     = 32'h20202020;

  // Status word layout
  localparam int          STAT_REQ_POS  = 0;
  localparam int          STAT_REL_POS  = 4;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  // Condition that counts as a release request
  typedef enum logic [1:0] {
    COND_LOW  = 2'b00,
    COND_HIGH = 2'b01,
    COND_FALL = 2'b10,
    COND_RISE = 2'b11
  } swsc_cond_t;

  // Power state reported by the standby controller
  typedef enum logic [1:0] {
    PWR_RUN   = 2'b00,
    PWR_IDLE  = 2'b01,
    PWR_SLEEP = 2'b10,
    PWR_STOP  = 2'b11
  } swsc_pwr_t;

endpackage

// File: rtl/swsc_detect.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// One wake source: condition detector gated by its enable
// ----------------------------------------------------------------------
module swsc_detect (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       pinIn,
  input  wire logic       wakeEnable,
  input  wire logic [1:0] wakeCond,
  output logic            wakeReq
);

  logic pinPrev_reg;
  logic primed_reg;
  logic wakeReq_reg;
  logic hit;

  // Previous sample; edges are ignored until one real sample exists,
  // so a pin already high at reset release is not taken as an edge
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pinPrev_reg <= 1'b0;
      primed_reg  <= 1'b0;
    end else begin
      pinPrev_reg <= pinIn;
      primed_reg  <= 1'b1;
    end
  end

  // Condition select
  always_comb begin
    case (swsc_pkg::swsc_cond_t'(wakeCond))
      swsc_pkg::COND_LOW:  hit = !pinIn;
      swsc_pkg::COND_HIGH: hit = pinIn;
      swsc_pkg::COND_FALL: hit = primed_reg && pinPrev_reg && !pinIn;
      swsc_pkg::COND_RISE: hit = primed_reg && !pinPrev_reg && pinIn;
      default:             hit = 1'b0;
    endcase
  end

  // Registered request, blocked while the enable is clear
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wakeReq_reg <= 1'b0;
    end else begin
      wakeReq_reg <= wakeEnable && hit;
    end
  end

  assign wakeReq = wakeReq_reg;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence riseSeen;
    !pinIn ##1 (pinIn && wakeEnable && wakeCond == 2'b11);
  endsequence

  sequence fallSeen;
    pinIn ##1 (!pinIn && wakeEnable && wakeCond == 2'b10);
  endsequence

  low_level_a: assert property (
    wakeEnable && wakeCond == 2'b00 && !pinIn |=> wakeReq)
    else $error("low level did not raise the wake request");
  high_level_a: assert property (
    wakeEnable && wakeCond == 2'b01 && pinIn |=> wakeReq)
    else $error("high level did not raise the wake request");
  rise_edge_a: assert property (
    riseSeen |=> wakeReq ##1 (!wakeReq || $rose(pinIn) || wakeCond != 2'b11))
    else $error("rising edge request missing or too long");
  fall_edge_a: assert property (
    fallSeen |=> wakeReq)
    else $error("falling edge did not raise the wake request");
  blocked_req_a: assert property (
    !wakeEnable |=> !wakeReq)
    else $error("disabled source raised a wake request");

endmodule

// File: rtl/swsc_wake_src.sv
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Standby wake source configuration for external inputs 4 to 7
// ----------------------------------------------------------------------
//
// Software writes one configuration word with a byte lane per input.
// Each lane holds a wake enable and a two-bit condition. The detectors
// raise a per-input request; the combined request is passed on to the
// standby controller while it reports a low-power state.
//
// Contract
// - Condition field picks low level, high level, falling or rising edge.
// - Enable bit 0 blocks the input's release request, 1 passes it.
// - Bits 7:6 and 3:1 of every lane are read-only zero.
// - Inputs 4..7 use lanes 0..3: enable at bit 0, condition at 5:4.
// - Reset gives falling edge everywhere and every enable cleared.
// - Any request may end stop, sleep and idle states.
module swsc_wake_src (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdata,
  input  wire logic        extIrqIn4,
  input  wire logic        extIrqIn5,
  input  wire logic        extIrqIn6,
  input  wire logic        extIrqIn7,
  input  wire logic [1:0]  powerState,
  output logic      [3:0]  wakeReq,
  output logic             standbyRelease
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [31:0] cfg_reg;
  logic [31:0] cfg_next;
  logic [31:0] regRdata_reg;
  logic [31:0] regRdata_next;
  logic        standbyRelease_reg;
  logic        standbyRelease_next;
  logic [3:0]  pinVec;
  logic [3:0]  laneEnable;
  logic [1:0]  laneCond [swsc_pkg::NUM_LANES];
  logic [3:0]  laneReq;
  logic [31:0] statusWord;
  logic        cfgWriteHit;
  logic        cfgReadHit;
  logic        statReadHit;
  logic        inStandby;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  // Used by both the write path and the read path
  function automatic logic addrHit(input logic [7:0] addr,
                                   input logic [7:0] offset);
    addrHit = (addr == offset);
  endfunction

  // Strobe qualified hits
  assign cfgWriteHit = regWrite && addrHit(regAddr, swsc_pkg::CFG_OFFSET);
  assign cfgReadHit  = regRead  && addrHit(regAddr, swsc_pkg::CFG_OFFSET);
  assign statReadHit = regRead  && addrHit(regAddr, swsc_pkg::STATUS_OFFSET);

  // ----------------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------------
  // Only the enable and condition bits store; the rest is dropped on
  // write so a read can never show anything but zero there
  always_comb begin
    cfg_next = cfg_reg;
    if (cfgWriteHit) begin
      cfg_next = regWdata & swsc_pkg::CFG_WMASK;
    end
  end

  // Storage with its reset value
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cfg_reg <= swsc_pkg::CFG_RESET;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // ----------------------------------------------------------------------
  // Per-lane fields and detectors
  // ----------------------------------------------------------------------
  // Input pins in lane order, input 4 in lane 0
  assign pinVec = {extIrqIn7, extIrqIn6, extIrqIn5, extIrqIn4};

  // One detector per byte lane
  genvar lane;
  generate
    for (lane = 0; lane < swsc_pkg::NUM_LANES; lane++) begin : gLane
      // Field extraction from the lane's byte
      assign laneEnable[lane] =
        cfg_reg[lane * swsc_pkg::LANE_W + swsc_pkg::EN_POS];
      assign laneCond[lane] =
        cfg_reg[lane * swsc_pkg::LANE_W + swsc_pkg::COND_POS +: swsc_pkg::COND_W];

      swsc_detect uDetect (
        .clk        (clk),
        .resetn     (resetn),
        .pinIn      (pinVec[lane]),
        .wakeEnable (laneEnable[lane]),
        .wakeCond   (laneCond[lane]),
        .wakeReq    (laneReq[lane])
      );
    end
  endgenerate

  // Detector outputs are already flip-flops
  assign wakeReq = laneReq;

  // ----------------------------------------------------------------------
  // Standby release
  // ----------------------------------------------------------------------
  // Any low-power state counts; running state needs no release
  always_comb begin
    case (swsc_pkg::swsc_pwr_t'(powerState))
      swsc_pkg::PWR_IDLE:  inStandby = 1'b1;
      swsc_pkg::PWR_SLEEP: inStandby = 1'b1;
      swsc_pkg::PWR_STOP:  inStandby = 1'b1;
      swsc_pkg::PWR_RUN:   inStandby = 1'b0;
      default:             inStandby = 1'b0;
    endcase
  end

  // Combined release, one cycle behind the per-input request
  assign standbyRelease_next = inStandby && (|laneReq);

  // Release register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      standbyRelease_reg <= 1'b0;
    end else begin
      standbyRelease_reg <= standbyRelease_next;
    end
  end

  assign standbyRelease = standbyRelease_reg;

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // Status shows the live requests and the release line
  always_comb begin
    statusWord = 32'h00000000;
    statusWord[swsc_pkg::STAT_REQ_POS +: 4] = laneReq;
    statusWord[swsc_pkg::STAT_REL_POS]      = standbyRelease_reg;
  end

  // Read data is valid only in the cycle after the strobe; an unmapped
  // address reads zero, so software never sees stale bus contents
  always_comb begin
    regRdata_next = 32'h00000000;
    if (cfgReadHit) begin
      regRdata_next = cfg_reg & swsc_pkg::CFG_WMASK;
    end else if (statReadHit) begin
      regRdata_next = statusWord;
    end
  end

  // Read data register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      regRdata_reg <= 32'h00000000;
    end else begin
      regRdata_reg <= regRdata_next;
    end
  end

  assign regRdata = regRdata_reg;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence cfgWriteThenRead;
    (regWrite && regAddr == 8'h14) ##1 (regRead && regAddr == 8'h14);
  endsequence

  sequence reqInStandby;
    (|laneReq) && powerState != 2'b00;
  endsequence

  resv_zero_a: assert property (
    @(posedge clk) disable iff (!resetn)
    regRead && regAddr == 8'h14 |=> (regRdata & 32'hcececece) == 32'h00000000)
    else $error("reserved configuration bits read as nonzero");

  lane_map_a: assert property (
    @(posedge clk) disable iff (!resetn)
    cfgWriteThenRead |=> regRdata == ($past(regWdata, 2) & 32'h31313131))
    else $error("configuration readback does not match written lanes");

  lane_enable_a: assert property (
    @(posedge clk) disable iff (!resetn)
    regWrite && regAddr == swsc_pkg::CFG_OFFSET
    |=> laneEnable[3] == $past(regWdata[24]))
    else $error("input 7 enable not taken from bit 24");

  reset_value_a: assert property (
    @(posedge clk) disable iff (!resetn)
    $rose(resetn) |-> cfg_reg == 32'h20202020 && wakeReq == 4'h0)
    else $error("configuration not at reset value after reset");

  release_a: assert property (
    @(posedge clk) disable iff (!resetn)
    reqInStandby |=> standbyRelease)
    else $error("wake request did not release standby");

  run_no_release_a: assert property (
    @(posedge clk) disable iff (!resetn)
    powerState == 2'b00 || laneReq == 4'h0 |=> !standbyRelease)
    else $error("release raised without request in standby");

  in4_request_a: assert property (
    @(posedge clk) disable iff (!resetn)
    cfg_reg[0] && cfg_reg[5:4] == 2'b01 && extIrqIn4 |=> wakeReq[0] ##1 1'b1)
    else $error("input 4 high level did not raise its request");

  // ----------------------------------------------------------------------
  // Checks on the register port and the per-input mapping
  // ----------------------------------------------------------------------
  // These watch the port and the stored configuration, so a wrong mask or a
  // swapped lane shows up even where no bench comparison looks; writes
  // and reads may come back to back, so none of them waits a cycle

  sequence cfgWrite;
    regWrite && regAddr == swsc_pkg::CFG_OFFSET;
  endsequence

  sequence statRead;
    regRead && regAddr == swsc_pkg::STATUS_OFFSET;
  endsequence

  // A write stores only the enable and condition bits
  cfg_store_a: assert property (
    @(posedge clk) disable iff (!resetn)
    cfgWrite |=> cfg_reg == ($past(regWdata) & swsc_pkg::CFG_WMASK))
    else $error("configuration write stored wrong bits");

  // Writes to any other address leave the configuration alone
  stray_write_a: assert property (
    @(posedge clk) disable iff (!resetn)
    regWrite && regAddr != swsc_pkg::CFG_OFFSET |=> $stable(cfg_reg))
    else $error("write to another address changed the configuration");

  // Read data stand for one cycle only; otherwise the port reads zero
  rdata_idle_a: assert property (
    @(posedge clk) disable iff (!resetn)
    !regRead |=> regRdata == 32'h00000000)
    else $error("read data not zero without a read");

  // Unmapped addresses read zero
  stray_read_a: assert property (
    @(posedge clk) disable iff (!resetn)
    regRead && regAddr != swsc_pkg::CFG_OFFSET && regAddr != swsc_pkg::STATUS_OFFSET
    |=> regRdata == 32'h00000000)
    else $error("unmapped address read nonzero");

  // Status shows the requests present at the read strobe
  status_req_a: assert property (
    @(posedge clk) disable iff (!resetn)
    statRead |=> regRdata[3:0] == $past(laneReq))
    else $error("status request bits do not match");

  // Release bit and zero upper bits of the status word
  status_rest_a: assert property (
    @(posedge clk) disable iff (!resetn)
    statRead |=> regRdata[31:4] == {27'h0, $past(standbyRelease_reg)})
    else $error("status release bit or upper bits wrong");

  // Outputs are quiet in the first cycle after reset
  reset_outputs_a: assert property (
    @(posedge clk) disable iff (!resetn)
    $rose(resetn) |-> !standbyRelease && regRdata == 32'h00000000)
    else $error("outputs not quiet after reset");

  // Input 7 low level lands on request bit 3
  in7_low_a: assert property (
    @(posedge clk) disable iff (!resetn)
    cfg_reg[24] && cfg_reg[29:28] == 2'b00 && !extIrqIn7 |=> wakeReq[3])
    else $error("input 7 low level did not raise its request");

  // Input 5 with its enable clear never requests
  in5_blocked_a: assert property (
    @(posedge clk) disable iff (!resetn)
    !cfg_reg[8] |=> !wakeReq[1])
    else $error("input 5 requested with its enable clear");

  // Input 6 falling edge lands on request bit 2
  in6_fall_a: assert property (
    @(posedge clk) disable iff (!resetn)
    cfg_reg[16] && cfg_reg[21:20] == 2'b10 && $fell(extIrqIn6) |=> wakeReq[2])
    else $error("input 6 falling edge did not raise its request");

endmodule

// File: test/swsc_pin_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Board side of external inputs 4 to 7
// ----------------------------------------------------------------------
module swsc_pin_model (
  input  wire logic [3:0] pinLevel,
  output logic            extIrqIn4,
  output logic            extIrqIn5,
  output logic            extIrqIn6,
  output logic            extIrqIn7
);
  // Push-pull board drivers already in the clock domain; the bench moves
  // them at a clock edge, so no settling delay is modelled here
  assign extIrqIn4 = pinLevel[0];
  assign extIrqIn5 = pinLevel[1];
  assign extIrqIn6 = pinLevel[2];
  assign extIrqIn7 = pinLevel[3];
endmodule

// File: test/tb.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin badCount++; \
  $display("BAD %s expected %0h seen %0h", nm, ex, got); end end
module tb;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic        clk;
  logic        resetn;
  logic [7:0]  regAddr;
  logic [31:0] regWdata;
  logic        regWrite;
  logic        regRead;
  logic [31:0] regRdata;
  logic [3:0]  pinLevel;
  logic        pin4;
  logic        pin5;
  logic        pin6;
  logic        pin7;
  logic [1:0]  powerState;
  logic [3:0]  wakeReq;
  logic        standbyRelease;
  int          badCount;
  int          checks;
  int          cycles;
  localparam logic [7:0] CFG  = swsc_pkg::CFG_OFFSET;
  localparam logic [7:0] STAT = swsc_pkg::STATUS_OFFSET;

  swsc_pin_model u_swsc_pin_model (.pinLevel(pinLevel), .extIrqIn4(pin4),
    .extIrqIn5(pin5), .extIrqIn6(pin6), .extIrqIn7(pin7));
  swsc_wake_src u_swsc_wake_src (.clk(clk), .resetn(resetn), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .extIrqIn4(pin4), .extIrqIn5(pin5), .extIrqIn6(pin6), .extIrqIn7(pin7),
    .powerState(powerState), .wakeReq(wakeReq), .standbyRelease(standbyRelease));

  // ----------------------------------------------------------------------
  // Clock and hang guard; a full sweep needs well under 2000 cycles
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      badCount++;
      wrapUp();
    end
  end

  // ----------------------------------------------------------------------
  // Register port tasks
  // ----------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 `CHK(nm, ex, regRdata)
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic check_reset();
    rd(CFG, 32'h20202020, "config after reset");
    `CHK("wake after reset", 4'h0, wakeReq)
    `CHK("release after reset", 1'b0, standbyRelease)
  endtask
  // Reserved bits, lane layout and decode of stray addresses
  task automatic check_fields();
    wr(CFG, 32'hffffffff);
    rd(CFG, 32'h31313131, "config all ones");
    wr(CFG, 32'h0);
    wr(8'h15, 32'hffffffff);
    rd(CFG, 32'h0, "config after stray write");
    rd(8'h15, 32'h0, "stray read");
    wr(STAT, 32'hffffffff);
    rd(STAT, 32'h0, "status read only");
  endtask
  // Every lane, condition, enable and power state; a request must land
  // only on its own lane bit, so a swapped lane shows at once
  task automatic lane_sweep();
    logic [1:0]  ps;
    logic        idle;
    logic        level;
    logic [31:0] word;
    logic [3:0]  hit;
    for (int n = 0; n < 4; n++) begin
      for (int c = 0; c < 4; c++) begin
        for (int en = 0; en < 2; en++) begin
          idle  = (c == 0 || c == 2);
          level = (c < 2);
          ps    = 2'(n + c);
          word  = 32'((c << 4) | en) << (8 * n);
          hit   = 4'(en << n);
          wr(CFG, 32'h0);
          pinLevel   <= {4{idle}};
          powerState <= ps;
          repeat (3) @(posedge clk);
          wr(CFG, word);
          rd(CFG, word, "config lane");
          repeat (2) @(posedge clk);
          #1 `CHK("wake at rest", 4'h0, wakeReq)
          @(posedge clk);
          pinLevel[n] <= ~idle;
          @(posedge clk);
          #1 `CHK("wake first", hit, wakeReq)
          @(posedge clk);
          #1 `CHK("wake second", (level ? hit : 4'h0), wakeReq)
          `CHK("release", (en == 1 && ps != 2'h0), standbyRelease)
          @(posedge clk);
          pinLevel[n] <= idle;
          repeat (2) @(posedge clk);
          #1 `CHK("wake back at rest", 4'h0, wakeReq)
          @(posedge clk);
          #1 `CHK("release cleared", 1'b0, standbyRelease)
        end
      end
    end
  endtask
  // Write then read with no gap, then two status reads in a row: the
  // request shows one cycle before the release bit does
  task automatic check_back_to_back();
    @(posedge clk);
    pinLevel   <= 4'h1;
    powerState <= 2'h2;
    regAddr    <= CFG;
    regWdata   <= 32'h00000011;
    regWrite   <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    regRead  <= 1'b1;
    @(posedge clk);
    regAddr <= STAT;
    #1 `CHK("config back to back", 32'h00000011, regRdata)
    @(posedge clk);
    #1 `CHK("status request", 32'h00000001, regRdata)
    @(posedge clk);
    regRead <= 1'b0;
    #1 `CHK("status release", 32'h00000011, regRdata)
  endtask
  // A reset in mid-run brings the fields back to their defaults
  task automatic reset_again();
    wr(CFG, 32'hffffffff);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(CFG, 32'h20202020, "config after second reset");
  endtask

  task automatic wrapUp();
    $display("Comparisons %0d mismatches %0d", checks, badCount);
    if (badCount == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    resetn     = 1'b0;
    regAddr    = 8'h00;
    regWdata   = 32'h0;
    regWrite   = 1'b0;
    regRead    = 1'b0;
    pinLevel   = 4'hf;
    powerState = 2'h0;
    badCount   = 0;
    checks     = 0;
    cycles     = 0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    check_reset();
    check_fields();
    lane_sweep();
    check_back_to_back();
    reset_again();
    wrapUp();
  end
endmodule
